//--- acc_pkg.sv
package acc_pkg;

  // Register indices and byte addresses (index times four)
  localparam logic [3:0]  ACC_IDX_FMT_RATE = 4'h0;
  localparam logic [3:0]  ACC_IDX_HS_GAIN  = 4'h1;
  localparam logic [3:0]  ACC_IDX_RSV_FILL = 4'he;
  localparam logic [3:0]  ACC_IDX_STATUS   = 4'h2;
  localparam logic [11:0] ACC_ADDR_FMT_RATE = 12'h000;
  localparam logic [11:0] ACC_ADDR_HS_GAIN  = 12'h004;
  localparam logic [11:0] ACC_ADDR_STATUS   = 12'h008;
  localparam logic [11:0] ACC_ADDR_RSV_FILL = 12'h038;

  // Field positions, format/rate register
  localparam int ACC_HPF_LSB  = 14;
  localparam int ACC_WORD_LENGTH_SELECT_LSB = 10;
  localparam int ACC_FMT_LSB  = 8;
  localparam int ACC_DACR_LSB = 3;
  localparam int ACC_ADCR_LSB = 0;
  // Field positions, headset gain register and fill register
  localparam int ACC_MUTE_POS = 15;
  localparam int ACC_GAIN_LSB = 8;
  localparam int ACC_TGT_LSB  = 5;
  localparam int ACC_TC_LSB   = 1;
  localparam int ACC_AGCEN_POS = 0;
  localparam int ACC_FILL_LSB = 8;

  // Writable masks
  localparam logic [15:0] ACC_FMT_RATE_WMASK = 16'hcf3f;
  localparam logic [15:0] ACC_HS_GAIN_WMASK  = 16'hffff;
  localparam logic [15:0] ACC_RSV_FILL_WMASK = 16'hff00;

  // Reset values
  localparam logic [15:0] ACC_FMT_RATE_RST = 16'h0000;
  localparam logic [15:0] ACC_HS_GAIN_RST  = 16'hff00;
  localparam logic [15:0] ACC_RSV_FILL_RST = 16'hff00;

  // Attack/decay times in ms, fixed whatever the sample rate
  localparam int ACC_MS_CYCLES = 20000;

  typedef enum logic [1:0] {ACC_HPF_OFF, ACC_HPF_0045, ACC_HPF_0125, ACC_HPF_025} acc_hpf_type;
  typedef enum logic [1:0] {ACC_WL_16, ACC_WL_20, ACC_WL_24, ACC_WL_32} acc_word_length_select_type;
  typedef enum logic [1:0] {ACC_FM_I2S, ACC_FM_DSP, ACC_FM_RJ, ACC_FM_LJ} acc_fmt_type;

  // Decoded audio configuration handed to the datapath
  typedef struct packed {
    acc_hpf_type  hpf_mode;
    logic [5:0]   hpf_corner_ppt;   // Corner, units of 0.0005 x Fs (0 = off)
    logic [5:0]   word_bits;
    acc_fmt_type  fmt;
    logic [3:0]   dac_div_x2;       // Divisor times two
    logic [3:0]   adc_div_x2;
    logic         rj_ratio_ok;
  } acc_audio_cfg_type;

  // Headset PGA control handed to the analog path
  typedef struct packed {
    logic         mute;
    logic [6:0]   gain_half_db;
    logic [5:0]   target_neg_half_db;
    logic [9:0]   attack_ms;
    logic [9:0]   decay_ms;
    logic         agc_on;
  } acc_pga_cfg_type;

endpackage

//--- acc_decode.sv
`timescale 1ns/1ns
module acc_decode
  import acc_pkg::*;
(
  input  wire logic [15:0]       fmt_rate_i,   // Format/rate register
  output acc_audio_cfg_type      cfg_o         // Decoded configuration
);

  // Divisor table in halves: 1,1.5,2,3,4,5,5.5,6
  function automatic logic [3:0] div_x2(input logic [2:0] code);
    logic [3:0] r;
    r = 4'h2;
    unique case (code)
      3'h0: r = 4'h2;
      3'h1: r = 4'h3;
      3'h2: r = 4'h4;
      3'h3: r = 4'h6;
      3'h4: r = 4'h8;
      3'h5: r = 4'ha;
      3'h6: r = 4'hb;
      3'h7: r = 4'hc;
    endcase
    return r;
  endfunction

  logic [3:0] dac_d;
  logic [3:0] adc_d;
  logic [7:0] prod_a;
  logic [7:0] prod_b;

  // Field decode
  always_comb begin
    dac_d = div_x2(fmt_rate_i[ACC_DACR_LSB +: 3]);
    adc_d = div_x2(fmt_rate_i[ACC_ADCR_LSB +: 3]);
    cfg_o.hpf_mode = acc_hpf_type'(fmt_rate_i[ACC_HPF_LSB +: 2]);
    unique case (fmt_rate_i[ACC_HPF_LSB +: 2])
      2'h0: cfg_o.hpf_corner_ppt = 6'h00;
      2'h1: cfg_o.hpf_corner_ppt = 6'h09;
      2'h2: cfg_o.hpf_corner_ppt = 6'h19;
      2'h3: cfg_o.hpf_corner_ppt = 6'h32;
    endcase
    unique case (fmt_rate_i[ACC_WORD_LENGTH_SELECT_LSB +: 2])
      2'h0: cfg_o.word_bits = 6'h10;
      2'h1: cfg_o.word_bits = 6'h14;
      2'h2: cfg_o.word_bits = 6'h18;
      2'h3: cfg_o.word_bits = 6'h20;
    endcase
    cfg_o.fmt = acc_fmt_type'(fmt_rate_i[ACC_FMT_LSB +: 2]);
    cfg_o.dac_div_x2 = dac_d;
    cfg_o.adc_div_x2 = adc_d;
    // Rates in integer ratio when one divisor divides the other
    prod_a = 8'(dac_d % adc_d);
    prod_b = 8'(adc_d % dac_d);
    cfg_o.rj_ratio_ok = (prod_a == 8'h00) || (prod_b == 8'h00);
  end

endmodule

//--- acc_regs.sv
`timescale 1ns/1ns
module acc_regs
  import acc_pkg::*;
(
  input  wire logic                mclk_i,         // 20 MHz clock
  input  wire logic                reset_i,        // Sync reset, active high
  input  wire logic                psel_i,         // APB select
  input  wire logic                penable_i,      // APB enable
  input  wire logic                pwrite_i,       // APB direction
  input  wire logic [11:0]         paddr_i,        // APB byte address
  input  wire logic [31:0]         pwdata_i,       // APB write data
  output logic                     pready_o,       // APB ready
  output logic [31:0]              prdata_o,       // APB read data
  output logic                     pslverr_o,      // APB error
  input  wire logic                hs_input_sel_i, // Headset/aux path selected, same clock
  input  wire logic [7:0]          agc_gain_i,     // AGC applied mute+gain, same clock
  output acc_audio_cfg_type        audio_cfg_o,    // Decoded audio configuration
  output acc_pga_cfg_type          pga_cfg_o,      // PGA drive to analog path
  output logic                     rj_invalid_o    // Right-justified with bad ratio
);

  logic [15:0]       fmt_rate_r;
  logic [15:0]       hs_gain_r;
  logic [15:0]       rsv_fill_r;
  logic [31:0]       prdata_r;
  logic              pslverr_r;
  logic [7:0]        agc_gain_r;
  logic              agc_view;
  logic [15:0]       hs_gain_view;
  logic              wr_en;
  logic              rd_en;
  logic              addr_ok;
  acc_audio_cfg_type audio_cfg;
  acc_pga_cfg_type   pga_nxt;
  acc_pga_cfg_type   pga_r;

  // Access decode; slave answers with no wait states
  assign wr_en   = psel_i & penable_i & pwrite_i;
  assign rd_en   = psel_i & ~penable_i & ~pwrite_i;
  assign addr_ok = (paddr_i == ACC_ADDR_FMT_RATE) || (paddr_i == ACC_ADDR_HS_GAIN) ||
                   (paddr_i == ACC_ADDR_STATUS) || (paddr_i == ACC_ADDR_RSV_FILL);
  assign pready_o  = 1'b1;
  assign pslverr_o = pslverr_r;
  assign prdata_o  = prdata_r;

  // Format and rate register
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fmt_rate_r <= ACC_FMT_RATE_RST;
    end else if (wr_en && paddr_i == ACC_ADDR_FMT_RATE) begin
      fmt_rate_r <= pwdata_i[15:0] & ACC_FMT_RATE_WMASK;
    end
  end

  // Headset gain register
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hs_gain_r <= ACC_HS_GAIN_RST;
    end else if (wr_en && paddr_i == ACC_ADDR_HS_GAIN) begin
      hs_gain_r <= pwdata_i[15:0] & ACC_HS_GAIN_WMASK;
    end
  end

  // Reserved fill register; writable lanes are the upper byte only
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rsv_fill_r <= ACC_RSV_FILL_RST;
    end else if (wr_en && paddr_i == ACC_ADDR_RSV_FILL) begin
      rsv_fill_r <= pwdata_i[15:0] & ACC_RSV_FILL_WMASK;
    end
  end

  // Capture the AGC gain report on this clock
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      agc_gain_r <= 8'hff;
    end else begin
      agc_gain_r <= agc_gain_i;
    end
  end

  // AGC applied mute+gain replaces the gain readback when enabled and headset input selected
  assign agc_view = hs_gain_r[ACC_AGCEN_POS] & hs_input_sel_i;
  always_comb begin
    hs_gain_view = hs_gain_r;
    if (agc_view) begin
      hs_gain_view[15:8] = agc_gain_r;
    end
  end

  // Read data and error, latched in setup phase
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel_i && !penable_i) begin
      pslverr_r <= ~addr_ok;
      prdata_r  <= 32'h0000_0000;
      if (rd_en) begin
        unique case (paddr_i)
          ACC_ADDR_FMT_RATE: prdata_r <= {16'h0000, fmt_rate_r};
          ACC_ADDR_HS_GAIN:  prdata_r <= {16'h0000, hs_gain_view};
          ACC_ADDR_STATUS:   prdata_r <= {30'h0, agc_view, audio_cfg.rj_ratio_ok};
          ACC_ADDR_RSV_FILL: prdata_r <= {16'h0000, rsv_fill_r};
          default:           prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  acc_decode u_decode (
    .fmt_rate_i (fmt_rate_r),
    .cfg_o      (audio_cfg)
  );

  // PGA control and AGC parameter decode
  always_comb begin
    pga_nxt.agc_on       = hs_gain_r[ACC_AGCEN_POS];
    pga_nxt.mute         = hs_gain_r[ACC_MUTE_POS];
    pga_nxt.gain_half_db = hs_gain_r[ACC_GAIN_LSB +: 7];
    unique case (hs_gain_r[ACC_TGT_LSB +: 3])
      3'h0: pga_nxt.target_neg_half_db = 6'd11;
      3'h1: pga_nxt.target_neg_half_db = 6'd16;
      3'h2: pga_nxt.target_neg_half_db = 6'd20;
      3'h3: pga_nxt.target_neg_half_db = 6'd24;
      3'h4: pga_nxt.target_neg_half_db = 6'd28;
      3'h5: pga_nxt.target_neg_half_db = 6'd34;
      3'h6: pga_nxt.target_neg_half_db = 6'd40;
      3'h7: pga_nxt.target_neg_half_db = 6'd48;
    endcase
    // Times in ms, independent of sample rate
    unique case (hs_gain_r[ACC_TC_LSB +: 2])
      2'h0: pga_nxt.attack_ms = 10'd8;
      2'h1: pga_nxt.attack_ms = 10'd11;
      2'h2: pga_nxt.attack_ms = 10'd16;
      2'h3: pga_nxt.attack_ms = 10'd20;
    endcase
    unique case (hs_gain_r[ACC_TC_LSB + 2 +: 2])
      2'h0: pga_nxt.decay_ms = 10'd100;
      2'h1: pga_nxt.decay_ms = 10'd200;
      2'h2: pga_nxt.decay_ms = 10'd400;
      2'h3: pga_nxt.decay_ms = 10'd500;
    endcase
  end

  // Registered PGA configuration output
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pga_r <= '0;
    end else begin
      pga_r <= pga_nxt;
    end
  end

  assign pga_cfg_o    = pga_r;
  assign audio_cfg_o  = audio_cfg;
  assign rj_invalid_o = (audio_cfg.fmt == ACC_FM_RJ) && !audio_cfg.rj_ratio_ok;

endmodule

//--- acc_regs_sva.sv
`timescale 1ns/1ns
module acc_regs_sva
  import acc_pkg::*;
(
  input wire logic              mclk_i,       // Clock
  input wire logic              reset_i,      // Reset
  input wire logic              psel_i,       // APB select
  input wire logic              penable_i,    // APB enable
  input wire logic              pwrite_i,     // APB direction
  input wire logic [11:0]       paddr_i,      // APB address
  input wire logic [31:0]       pwdata_i,     // APB write data
  input wire logic              pready_o,     // APB ready
  input wire logic [31:0]       prdata_o,     // APB read data
  input wire logic              pslverr_o,    // APB error
  input wire acc_audio_cfg_type audio_cfg_o,  // Audio decode
  input wire acc_pga_cfg_type   pga_cfg_o,    // PGA drive
  input wire logic              rj_invalid_o  // Bad ratio flag
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic acc_a;
  logic acc_map;
  // Access phase and address decode
  assign acc_a = psel_i && penable_i;
  assign acc_map = paddr_i inside {ACC_ADDR_FMT_RATE, ACC_ADDR_HS_GAIN, ACC_ADDR_STATUS, ACC_ADDR_RSV_FILL};
  chk_ready_high: assert property (pready_o) else $error("ready low");
  chk_upper_zero: assert property (prdata_o[31:16] == 16'h0000) else $error("upper data set");
  chk_err_unmapped: assert property (acc_a |-> pslverr_o == !acc_map) else $error("bad error flag");
  chk_fmt_rsvd: assert property (
    acc_a && !pwrite_i && paddr_i == ACC_ADDR_FMT_RATE |-> (prdata_o & 32'h000030c0) == 32'h0)
    else $error("reserved bits set");
  chk_fill_rsvd: assert property (
    acc_a && !pwrite_i && paddr_i == ACC_ADDR_RSV_FILL |-> prdata_o[7:0] == 8'h00)
    else $error("fill low byte set");
  chk_fmt_decode: assert property (
    acc_a && pwrite_i && paddr_i == ACC_ADDR_FMT_RATE |=> audio_cfg_o.fmt == $past(pwdata_i[9:8])
    && audio_cfg_o.hpf_mode == $past(pwdata_i[15:14])) else $error("format decode");
  chk_rj_flag: assert property (
    rj_invalid_o == (audio_cfg_o.fmt == ACC_FM_RJ && !audio_cfg_o.rj_ratio_ok)) else $error("ratio flag");
  chk_pga_follow: assert property (
    acc_a && pwrite_i && paddr_i == ACC_ADDR_HS_GAIN && !pwdata_i[0] |=> ##1
    {pga_cfg_o.mute, pga_cfg_o.gain_half_db} == $past(pwdata_i[15:8], 2) && !pga_cfg_o.agc_on)
    else $error("pga not following");
endmodule
bind acc_regs acc_regs_sva chk (.mclk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pready_o, .prdata_o, .pslverr_o, .audio_cfg_o, .pga_cfg_o, .rj_invalid_o);

//--- acc_regs_tb.sv
`timescale 1ns/1ns
module acc_regs_tb;
  import acc_pkg::*;
  logic              mclk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic              pwrite_i = 1'b0, hs_input_sel_i = 1'b0, pready_o, pslverr_o, rj_invalid_o, er;
  logic [11:0]       paddr_i = 12'h000;
  logic [31:0]       pwdata_i = 32'h0, prdata_o, rd;
  logic [7:0]        agc_gain_i = 8'h00;
  acc_audio_cfg_type audio_cfg_o;
  acc_pga_cfg_type   pga_cfg_o;
  int                err_count = 0, checks_done = 0, cyc = 0;
  // Clock and cycle ceiling
  always #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  acc_regs dut (.mclk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
    .prdata_o, .pslverr_o, .hs_input_sel_i, .agc_gain_i, .audio_cfg_o, .pga_cfg_o, .rj_invalid_o);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {16'h0000, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    chk(rd, {16'h0000, e});
  endtask
  task automatic t_reset;
    rdchk(ACC_ADDR_FMT_RATE, 16'h0000);
    rdchk(ACC_ADDR_HS_GAIN, 16'hff00);
    rdchk(ACC_ADDR_RSV_FILL, 16'hff00);
    chk({pga_cfg_o.mute, pga_cfg_o.gain_half_db}, 8'hff);
  endtask
  task automatic t_fmt;
    int hw[4] = '{0, 9, 25, 50};
    int wl[4] = '{16, 20, 24, 32};
    int dv[8] = '{2, 3, 4, 6, 8, 10, 11, 12};
    logic [15:0] rv[4] = '{16'h0200, 16'h0208, 16'h0228, 16'h0108};
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {i[1:0], 2'b11, i[1:0], i[1:0], 2'b11, i[2:0], 3'(7 - i)};
      apb(1'b1, ACC_ADDR_FMT_RATE, v);
      rdchk(ACC_ADDR_FMT_RATE, v & 16'hcf3f);
      chk(audio_cfg_o.hpf_corner_ppt, hw[i % 4]);
      chk(audio_cfg_o.word_bits, wl[i % 4]);
      chk(audio_cfg_o.fmt, i % 4);
      chk(audio_cfg_o.dac_div_x2, dv[i]);
      chk(audio_cfg_o.adc_div_x2, dv[7 - i]);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ACC_ADDR_FMT_RATE, rv[i]);
      rdchk(ACC_ADDR_STATUS, {15'h0000, i[0] == 1'b0});
      chk(rj_invalid_o, i == 1);
    end
  endtask
  task automatic t_gain;
    int tgt[8] = '{11, 16, 20, 24, 28, 34, 40, 48};
    int atk[4] = '{8, 11, 16, 20};
    int dcy[4] = '{100, 200, 400, 500};
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {8'h55, i[2:0], i[1:0], ~i[1:0], 1'b0};
      apb(1'b1, ACC_ADDR_HS_GAIN, v);
      rdchk(ACC_ADDR_HS_GAIN, v);
      chk(pga_cfg_o.target_neg_half_db, tgt[i]);
      chk({pga_cfg_o.mute, pga_cfg_o.gain_half_db, pga_cfg_o.agc_on}, 9'h0aa);
      chk({pga_cfg_o.attack_ms, pga_cfg_o.decay_ms}, {10'(atk[3 - i % 4]), 10'(dcy[i % 4])});
    end
  endtask
  task automatic t_agc;
    hs_input_sel_i <= 1'b1;
    agc_gain_i <= 8'ha3;
    apb(1'b1, ACC_ADDR_HS_GAIN, 16'h2a01);
    rdchk(ACC_ADDR_HS_GAIN, 16'ha301);
    chk(pga_cfg_o.agc_on, 1'b1);
    hs_input_sel_i <= 1'b0;
    rdchk(ACC_ADDR_HS_GAIN, 16'h2a01);
  endtask
  task automatic t_bad;
    apb(1'b1, 12'h010, 16'hffff);
    chk(er, 1'b1);
    rdchk(12'h010, 16'h0000);
    chk(er, 1'b1);
    apb(1'b1, ACC_ADDR_RSV_FILL, 16'hffff);
    rdchk(ACC_ADDR_RSV_FILL, 16'hff00);
  endtask
  task automatic give_verdict;
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    t_reset();
    t_fmt();
    t_gain();
    t_agc();
    t_bad();
    give_verdict();
  end
endmodule
